// ---- common/bcwc_defs.svh ----
// Field positions, codes and register offsets of the boot configuration decoder
`ifndef BCWC_DEFS_SVH
`define BCWC_DEFS_SVH

// Byte offsets on the register bus
`define BCWC_OFS_CFG1        4'h0
`define BCWC_OFS_CFG2        4'h4
`define BCWC_OFS_WDT_DEC     4'h8
`define BCWC_OFS_CLK_DEC     4'hc
`define BCWC_ADDR_W          4

// First word: clock and watchdog
`define BCWC_WINSZ_HI        25
`define BCWC_WINSZ_LO        24
`define BCWC_WDT_EN_BIT      23
`define BCWC_WIN_DIS_BIT     22
`define BCWC_PS_HI           20
`define BCWC_PS_LO           16
`define BCWC_CKSM_HI         15
`define BCWC_CKSM_LO         14
`define BCWC_PBDIV_HI        13
`define BCWC_PBDIV_LO        12
`define BCWC_CLOCK_OUTPUT_DIS_BIT    10
`define BCWC_POSC_HI         9
`define BCWC_POSC_LO         8
`define BCWC_TWO_SPEED_STARTUP_EN_BIT        7
`define BCWC_SOSC_BIT        5
`define BCWC_NOSC_HI         2
`define BCWC_NOSC_LO         0

// Second word: PLL
`define BCWC_PLLODIV_HI      18
`define BCWC_PLLODIV_LO      16
`define BCWC_UPLL_BYP_BIT    15
`define BCWC_USB_PLL_INPUT_DIV_HI     10
`define BCWC_USB_PLL_INPUT_DIV_LO     8
`define BCWC_PLLMUL_HI       6
`define BCWC_PLLMUL_LO       4
`define BCWC_PLLIDIV_HI      2
`define BCWC_PLLIDIV_LO      0

// Codes
`define BCWC_PS_MAX          5'h14
`define BCWC_POSC_OFF        2'h3
`define BCWC_POSC_EC         2'h0
`define BCWC_CKSM_SW_ONLY    2'h1
`define BCWC_CKSM_BOTH       2'h0
`define BCWC_MUL_TOP_CODE    3'h7
`define BCWC_MUL_BASE        5'h0f
`define BCWC_MUL_TOP         5'h18

// Reset value of the captured words (all ones is an erased device) and the all-zero read data word
`define BCWC_WORD_RST        32'hffffffff
`define BCWC_WORD_ZERO       32'h00000000

`endif

// ---- common/bcwc_pkg.sv ----
// Types of the boot configuration decoder
package bcwc_pkg;

  typedef enum logic [2:0] {
    BCWC_OSC_FRC      = 3'b000,
    BCWC_OSC_FRC_PLL  = 3'b001,
    BCWC_OSC_PRI      = 3'b010,
    BCWC_OSC_PRI_PLL  = 3'b011,
    BCWC_OSC_SEC      = 3'b100,
    BCWC_OSC_LOW_POWER_RC_OSC     = 3'b101,
    BCWC_OSC_FRC_D16  = 3'b110,
    BCWC_OSC_FRC_DIVN = 3'b111
  } bcwc_osc_t;

  typedef enum logic [1:0] {
    BCWC_POSC_EXT = 2'b00,
    BCWC_POSC_XT  = 2'b01,
    BCWC_POSC_HS  = 2'b10,
    BCWC_POSC_DIS = 2'b11
  } bcwc_posc_t;

  typedef enum logic [1:0] {
    BCWC_WIN_75   = 2'b00,
    BCWC_WIN_50   = 2'b01,
    BCWC_WIN_37P5 = 2'b10,
    BCWC_WIN_25   = 2'b11
  } bcwc_win_t;

  typedef enum logic [1:0] {
    BCWC_ST_LOAD = 2'b00,
    BCWC_ST_HOLD = 2'b01
  } bcwc_state_t;

endpackage

// ---- verilog/bcwc_config_decode.sv ----
// Boot configuration word capture and decode for clock system and watchdog
//
// Functional notes
// - Window size code picks 25/37.5/50/75 percent
// - Enable fuse forces watchdog on, software locked
// - Window disable fuse selects non-window mode
// - Postscale code n gives ratio 1:2^n
// - Postscale codes above 10100 act as 10100
// - Switch/monitor field: 1x none, 01 switch, 00 both
// - Bus divisor codes give divide by 1/2/4/8
// - Clock output only when enabled and primary off/external
// - Primary mode: off, high-speed, standard, external clock
// - Switchover fuse enables two-speed start-up
// - Secondary oscillator fuse enables secondary oscillator
// - Initial oscillator select chooses among eight sources
// - PLL output divisor 1,2,4..64,256
// - USB PLL fuse one bypasses, zero enables
// - Multiplier 15..21, code 111 gives 24
// - System PLL input divider 1..6,10,12, same encoding as USB PLL input divider
// - USB fields act only when USB present
`timescale 1ns/100ps
`include "bcwc_defs.svh"

module bcwc_config_decode #(
  parameter bit USB_PRESENT = 1'b1
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  input  wire logic [31:0]               i_cfg_word1,
  input  wire logic [31:0]               i_cfg_word2,
  input  wire logic [`BCWC_ADDR_W-1:0]   i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  output logic      [1:0]                o_avs_response,
  output logic                           o_cfg_valid,
  output logic      [1:0]                o_wdt_window_size,
  output logic      [2:0]                o_wdt_window_eighths,
  output logic                           o_wdt_fuse_enable,
  output logic                           o_wdt_sw_ctrl_allowed,
  output logic                           o_wdt_window_mode,
  output logic      [4:0]                o_wdt_postscale_sel,
  output logic                           o_clk_switch_en,
  output logic                           o_fail_safe_mon_en,
  output logic      [3:0]                o_periph_bus_div,
  output logic                           o_clock_output_en,
  output logic      [1:0]                o_primary_osc_mode,
  output logic                           o_two_speed_startup_en,
  output logic                           o_secondary_osc_en,
  output logic      [2:0]                o_initial_osc_sel,
  output logic      [8:0]                o_pll_output_div,
  output logic                           o_usb_pll_bypass,
  output logic      [3:0]                o_usb_pll_input_div,
  output logic      [4:0]                o_pll_multiplier,
  output logic      [3:0]                o_pll_input_div
);

  bcwc_pkg::bcwc_state_t state;
  logic [31:0] word1;
  logic [31:0] word2;
  logic        rd_pending;

  // Shared input divider encoding of both PLLs
  function automatic logic [3:0] in_div(input logic [2:0] code);
    unique case (code)
      3'h0: in_div = 4'h1;
      3'h1: in_div = 4'h2;
      3'h2: in_div = 4'h3;
      3'h3: in_div = 4'h4;
      3'h4: in_div = 4'h5;
      3'h5: in_div = 4'h6;
      3'h6: in_div = 4'ha;
      3'h7: in_div = 4'hc;
    endcase
  endfunction

  // Capture happens one cycle after reset release; the words are not resampled until the next reset so that
  // a glitch on the fuse array later on cannot move the clock tree under running code.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state <= bcwc_pkg::BCWC_ST_LOAD;
    end else begin
      unique case (state)
        bcwc_pkg::BCWC_ST_LOAD: state <= bcwc_pkg::BCWC_ST_HOLD;
        bcwc_pkg::BCWC_ST_HOLD: state <= bcwc_pkg::BCWC_ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      word1 <= `BCWC_WORD_RST;
      word2 <= `BCWC_WORD_RST;
    end else if (state == bcwc_pkg::BCWC_ST_LOAD) begin
      word1 <= i_cfg_word1;
      word2 <= i_cfg_word2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_cfg_valid <= 1'b0;
    end else begin
      // Rises with the first decode of the captured words, not with the capture itself
      o_cfg_valid <= (state == bcwc_pkg::BCWC_ST_HOLD) | o_cfg_valid;
    end
  end

  // Field slices of the captured words
  logic [1:0] f_winsz;
  logic [4:0] f_ps;
  logic [1:0] f_cksm;
  logic [1:0] f_pbdiv;
  logic [1:0] f_posc;
  logic [2:0] f_odiv;
  logic [2:0] f_mul;
  assign f_winsz = word1[`BCWC_WINSZ_HI:`BCWC_WINSZ_LO];
  assign f_ps    = word1[`BCWC_PS_HI:`BCWC_PS_LO];
  assign f_cksm  = word1[`BCWC_CKSM_HI:`BCWC_CKSM_LO];
  assign f_pbdiv = word1[`BCWC_PBDIV_HI:`BCWC_PBDIV_LO];
  assign f_posc  = word1[`BCWC_POSC_HI:`BCWC_POSC_LO];
  assign f_odiv  = word2[`BCWC_PLLODIV_HI:`BCWC_PLLODIV_LO];
  assign f_mul   = word2[`BCWC_PLLMUL_HI:`BCWC_PLLMUL_LO];

  // Watchdog defaults
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_wdt_window_size     <= 2'h3;
      o_wdt_window_eighths  <= 3'h2;
      o_wdt_fuse_enable     <= 1'b0;
      o_wdt_sw_ctrl_allowed <= 1'b0;
      o_wdt_window_mode     <= 1'b0;
      o_wdt_postscale_sel   <= `BCWC_PS_MAX;
    end else begin
      o_wdt_window_size <= f_winsz;
      unique case (f_winsz)
        bcwc_pkg::BCWC_WIN_25:   o_wdt_window_eighths <= 3'h2;
        bcwc_pkg::BCWC_WIN_37P5: o_wdt_window_eighths <= 3'h3;
        bcwc_pkg::BCWC_WIN_50:   o_wdt_window_eighths <= 3'h4;
        bcwc_pkg::BCWC_WIN_75:   o_wdt_window_eighths <= 3'h6;
      endcase
      o_wdt_fuse_enable     <= word1[`BCWC_WDT_EN_BIT];
      o_wdt_sw_ctrl_allowed <= (state == bcwc_pkg::BCWC_ST_HOLD) & ~word1[`BCWC_WDT_EN_BIT];
      o_wdt_window_mode     <= ~word1[`BCWC_WIN_DIS_BIT];
      // Exponent n of the ratio 1:2^n, clamped at the top code
      o_wdt_postscale_sel <= (f_ps > `BCWC_PS_MAX) ? `BCWC_PS_MAX : f_ps;
    end
  end

  // Oscillator and bus clock defaults
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_clk_switch_en        <= 1'b0;
      o_fail_safe_mon_en     <= 1'b0;
      o_periph_bus_div       <= 4'h1;
      o_clock_output_en      <= 1'b0;
      o_primary_osc_mode     <= `BCWC_POSC_OFF;
      o_two_speed_startup_en <= 1'b0;
      o_secondary_osc_en     <= 1'b0;
      o_initial_osc_sel      <= 3'h0;
    end else begin
      o_clk_switch_en    <= (f_cksm == `BCWC_CKSM_SW_ONLY) | (f_cksm == `BCWC_CKSM_BOTH);
      o_fail_safe_mon_en <= (f_cksm == `BCWC_CKSM_BOTH);
      o_periph_bus_div   <= 4'h1 << f_pbdiv;
      o_clock_output_en  <= (state == bcwc_pkg::BCWC_ST_HOLD) & ~word1[`BCWC_CLOCK_OUTPUT_DIS_BIT]
                            & ((f_posc == `BCWC_POSC_OFF) | (f_posc == `BCWC_POSC_EC));
      o_primary_osc_mode     <= f_posc;
      o_two_speed_startup_en <= word1[`BCWC_TWO_SPEED_STARTUP_EN_BIT];
      o_secondary_osc_en     <= word1[`BCWC_SOSC_BIT];
      // is not enforced: a disabled primary with a primary source is passed on as programmed
      o_initial_osc_sel <= word1[`BCWC_NOSC_HI:`BCWC_NOSC_LO];
    end
  end

  // PLL defaults
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pll_output_div    <= 9'h001;
      o_usb_pll_bypass    <= 1'b1;
      o_usb_pll_input_div <= 4'h1;
      o_pll_multiplier    <= `BCWC_MUL_BASE;
      o_pll_input_div     <= 4'h1;
    end else begin
      // Code 111 skips 128 and jumps to 256
      o_pll_output_div <= (f_odiv == 3'h7) ? 9'h100 : (9'h001 << f_odiv);
      // Without the USB function the USB PLL stays bypassed at unit divide
      o_usb_pll_bypass    <= USB_PRESENT ? word2[`BCWC_UPLL_BYP_BIT] : 1'b1;
      o_usb_pll_input_div <= USB_PRESENT ? in_div(word2[`BCWC_USB_PLL_INPUT_DIV_HI:`BCWC_USB_PLL_INPUT_DIV_LO]) : 4'h1;
      o_pll_multiplier <= (f_mul == `BCWC_MUL_TOP_CODE) ? `BCWC_MUL_TOP
                          : (`BCWC_MUL_BASE + {2'h0, f_mul});
      o_pll_input_div <= in_div(word2[`BCWC_PLLIDIV_HI:`BCWC_PLLIDIV_LO]);
    end
  end

  // Avalon-MM slave: one wait cycle on reads, writes accepted at once and answered with slave error
  logic [31:0] wdt_status;
  logic [31:0] clk_status;
  assign wdt_status = {22'h0, o_cfg_valid, o_wdt_fuse_enable, o_wdt_window_mode,
                       o_wdt_window_size, o_wdt_postscale_sel};
  assign clk_status = {12'h0, o_clk_switch_en, o_fail_safe_mon_en, o_clock_output_en,
                       o_two_speed_startup_en, o_secondary_osc_en, o_usb_pll_bypass,
                       o_primary_osc_mode, o_periph_bus_div, o_initial_osc_sel, o_pll_multiplier};

  assign o_avs_waitrequest = i_avs_read & ~rd_pending;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= i_avs_read & ~rd_pending;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_avs_readdata <= `BCWC_WORD_ZERO;
      o_avs_response <= 2'h0;
    end else if (i_avs_read & ~rd_pending) begin
      o_avs_response <= 2'h0;
      unique case (i_avs_address)
        `BCWC_OFS_CFG1:    o_avs_readdata <= word1;
        `BCWC_OFS_CFG2:    o_avs_readdata <= word2;
        `BCWC_OFS_WDT_DEC: o_avs_readdata <= wdt_status;
        `BCWC_OFS_CLK_DEC: o_avs_readdata <= clk_status;
        default: begin
          o_avs_readdata <= `BCWC_WORD_ZERO;
          o_avs_response <= 2'h2;
        end
      endcase
    end else if (i_avs_write) begin
      // All registers are read-only; a write answers with slave error
      o_avs_response <= 2'h2;
    end
  end

endmodule

// ---- verification/bcwc_config_decode_chk.sv ----
// Port checker for the boot configuration decoder
`timescale 1ns/100ps
module bcwc_chk (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       o_cfg_valid,
  input wire logic [1:0] o_wdt_window_size,
  input wire logic [2:0] o_wdt_window_eighths,
  input wire logic       o_wdt_fuse_enable,
  input wire logic       o_wdt_sw_ctrl_allowed,
  input wire logic [4:0] o_wdt_postscale_sel,
  input wire logic       o_clk_switch_en,
  input wire logic       o_fail_safe_mon_en,
  input wire logic       o_clock_output_en,
  input wire logic [1:0] o_primary_osc_mode,
  input wire logic [4:0] o_pll_multiplier
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_win;
    o_cfg_valid |-> o_wdt_window_eighths == (o_wdt_window_size == 2'h3 ? 3'h2 :
      o_wdt_window_size == 2'h2 ? 3'h3 : o_wdt_window_size == 2'h1 ? 3'h4 : 3'h6);
  endproperty
  a_win: assert property (p_win) else $error("window eighths do not match size code");
  property p_lock;
    o_cfg_valid |-> o_wdt_sw_ctrl_allowed != o_wdt_fuse_enable;
  endproperty
  a_lock: assert property (p_lock) else $error("software control not locked by fuse");
  property p_ps;
    o_wdt_postscale_sel <= 5'h14;
  endproperty
  a_ps: assert property (p_ps) else $error("postscale beyond largest ratio");
  property p_fsm;
    o_fail_safe_mon_en |-> o_clk_switch_en;
  endproperty
  a_fsm: assert property (p_fsm) else $error("monitor on without switching");
  property p_clock_output;
    o_clock_output_en |-> o_cfg_valid && o_primary_osc_mode inside {2'h0, 2'h3};
  endproperty
  a_clock_output: assert property (p_clock_output) else $error("clock output with crystal mode");
  property p_mul;
    o_cfg_valid |-> o_pll_multiplier inside {[5'h0f:5'h15], 5'h18};
  endproperty
  a_mul: assert property (p_mul) else $error("multiplier outside its set");
  property p_hold;
    o_cfg_valid |=> o_cfg_valid && $stable(o_pll_multiplier) && $stable(o_wdt_postscale_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("decoded value moved after capture");
  property p_start;
    $rose(i_nrst) |-> !o_cfg_valid [*2] ##1 o_cfg_valid;
  endproperty
  a_start: assert property (p_start) else $error("capture not two edges after release");
  c_clock_output: cover property (o_clock_output_en);
  c_fsm: cover property (o_fail_safe_mon_en);
  c_sw: cover property (o_wdt_sw_ctrl_allowed);
endmodule

bind bcwc_config_decode bcwc_chk u_chk (.*);

// ---- verification/tb_bcwc_config_decode.sv ----
// Self-checking bench for the boot configuration decoder
`timescale 1ns/100ps
module tb_bcwc_config_decode;
  logic        i_clk = 1'b0, i_nrst = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0]  i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
  logic [31:0] i_cfg_word1 = 32'hffffffff, i_cfg_word2 = 32'hffffffff, i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata, rdv;
  logic [1:0]  o_avs_response, o_wdt_window_size, o_primary_osc_mode, rsp;
  logic        o_avs_waitrequest, o_cfg_valid, o_wdt_fuse_enable, o_wdt_sw_ctrl_allowed, o_wdt_window_mode;
  logic        o_clk_switch_en, o_fail_safe_mon_en, o_clock_output_en, o_two_speed_startup_en;
  logic        o_secondary_osc_en, o_usb_pll_bypass;
  logic [2:0]  o_wdt_window_eighths, o_initial_osc_sel;
  logic [3:0]  o_periph_bus_div, o_usb_pll_input_div, o_pll_input_div;
  logic [4:0]  o_wdt_postscale_sel, o_pll_multiplier;
  logic [8:0]  o_pll_output_div;
  int          fail_count = 0, check_count = 0;

  bcwc_config_decode #(.USB_PRESENT(1'b1)) dut_u (.*);

  always #5 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Held until the rising edge that samples waitrequest low; data taken at that edge
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= wd;
    i_avs_write <= we;
    i_avs_read <= !we;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    rdv = o_avs_readdata;
    rsp = o_avs_response;
    if (n >= 20) fail_count++;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic boot(input logic [31:0] a, input logic [31:0] b);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    i_cfg_word1 <= a;
    i_cfg_word2 <= b;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic t_regs();
    boot(32'hfebf697a, 32'hfffb7fd9);
    bus(1'b0, 4'h0, 32'h0);
    chk(rdv, 32'hfebf697a);
    chk(rsp, 2'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk(rdv, 32'hfffb7fd9);
    bus(1'b0, 4'h8, 32'h0);
    chk(rdv, 32'h3d4);
    bus(1'b1, 4'h0, 32'h0);
    @(negedge i_clk);
    chk(o_avs_response, 2'h2);
    i_cfg_word1 <= 32'h0;
    bus(1'b0, 4'h2, 32'h0);
    chk(rdv, 32'h0);
    chk(rsp, 2'h2);
    bus(1'b0, 4'h0, 32'h0);
    chk(rdv, 32'hfebf697a);
    @(negedge i_clk);
    chk(o_wdt_fuse_enable, 1'b1);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
    chk({o_cfg_valid, o_clock_output_en}, 2'h0);
  endtask

  task automatic t_sweep();
    logic [2:0] k;
    logic [1:0] p;
    logic [4:0] s;
    int div[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      p = ~k[1:0];
      s = {k, 2'b00};
      boot({6'h3f, k[1:0], k[0], k[1], 1'b1, s, k[1:0], k[1:0], 1'b1, k[2], p, k[0], 1'b1, k[1], 2'h3, k},
           {13'h1fff, k, k[0], 4'hf, k, 1'b1, k, 1'b1, k});
      chk(o_wdt_window_eighths, k[1:0] == 2'h3 ? 2 : k[1:0] == 2'h2 ? 3 : k[0] ? 4 : 6);
      chk({o_wdt_fuse_enable, o_wdt_sw_ctrl_allowed}, {k[0], !k[0]});
      chk(o_wdt_window_mode, !k[1]);
      chk(o_wdt_postscale_sel, s > 5'h14 ? 5'h14 : s);
      chk({o_clk_switch_en, o_fail_safe_mon_en}, {!k[1], k[1:0] == 2'h0});
      chk(o_periph_bus_div, 4'h1 << k[1:0]);
      chk(o_clock_output_en, !k[2] && (p == 2'h3 || p == 2'h0));
      chk(o_primary_osc_mode, p);
      chk({o_two_speed_startup_en, o_secondary_osc_en}, {k[0], k[1]});
      chk(o_initial_osc_sel, k);
      chk(o_pll_output_div, k == 3'h7 ? 256 : 1 << k);
      chk({o_usb_pll_bypass, o_usb_pll_input_div}, {k[0], div[i][3:0]});
      chk(o_pll_multiplier, k == 3'h7 ? 24 : 15 + k);
      chk(o_pll_input_div, div[i]);
    end
  endtask

  initial begin
    t_regs();
    t_sweep();
    summarize();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule
